// ### hw/icr_top.sv
// Purpose: Two-way read cache with address remap on the fetch bus
// Assumes: Single slave on the execution port, HREADY fed back by the bus
// Notes: Master error responses are not reported back to the core

module icr_top
  import icr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input icr_exe_req_t EXE_REQ_I,
  input wire logic [31:0] EXE_HWDATA_I,
  output logic EXE_HREADYOUT_O,
  output logic [31:0] EXE_HRDATA_O,
  output icr_mst_req_t M0_REQ_O,
  input wire logic M0_HREADY_I,
  input wire logic [31:0] M0_HRDATA_I,
  output icr_mst_req_t M1_REQ_O,
  input wire logic M1_HREADY_I,
  input wire logic [31:0] M1_HRDATA_I,
  output logic IRQ_O
);
  // ***********************************************************
  // Register bus
  // ***********************************************************
  logic ack_q, en_q, bstt_q, amsel_q, hmen_q, mmen_q;
  logic busy_q, end_q, err_q, endie_q, errie_q;
  logic [31:0] dat_q, hit_cnt_q, rd_val, wmask, wdat;
  logic [15:0] miss_cnt_q;
  logic [9:0] inv_idx_q;
  icr_region_t region_q [ICR_REGIONS];
  logic wb_req, wb_wr, wr_ctl, wr_fc, wr_cfg, invalidate_request_start, inv_done;
  logic hit_evt, miss_evt, err_evt;
  logic [7:0] adr;

  assign adr = {WB_ADR_I[7:2], 2'b00};
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wb_wr = wb_req & WB_WE_I;
  assign wr_ctl = wb_wr & (adr == REG_CTL);
  assign wr_fc = wb_wr & (adr == REG_FC);
  assign wr_cfg = wb_wr & (adr[7:4] == REG_CFG0[7:4]);
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                  {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wdat = (rd_val & ~wmask) | (WB_DAT_I & wmask);

  always_comb begin
    rd_val = 32'h0;
    case (adr)
      REG_CTL: begin
        rd_val[CTL_EN] = en_q;
        rd_val[CTL_AMSEL] = amsel_q;
        rd_val[CTL_BSTT] = bstt_q;
        rd_val[CTL_HMEN] = hmen_q;
        rd_val[CTL_MMEN] = mmen_q;
      end
      REG_STAT: begin
        rd_val[STAT_BUSY] = busy_q;
        rd_val[STAT_END] = end_q;
        rd_val[STAT_ERR] = err_q;
      end
      REG_INTEN: begin
        rd_val[STAT_END] = endie_q;
        rd_val[STAT_ERR] = errie_q;
      end
      REG_HMC: rd_val = hit_cnt_q;
      REG_MMC: rd_val = {16'h0, miss_cnt_q};
      default: begin
        if (adr[7:4] == REG_CFG0[7:4]) begin
          rd_val = region_q[adr[3:2]];
        end
      end
    endcase
  end

  // Unmapped offsets still acknowledge and read as zero
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= rd_val;
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      en_q <= 1'b0;
      bstt_q <= 1'b0;
      amsel_q <= CTL_AMSEL_RST;
      hmen_q <= 1'b0;
      mmen_q <= 1'b0;
      endie_q <= 1'b0;
      errie_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        en_q <= wdat[CTL_EN];
        bstt_q <= wdat[CTL_BSTT];
        amsel_q <= wdat[CTL_AMSEL];
        hmen_q <= wdat[CTL_HMEN];
        mmen_q <= wdat[CTL_MMEN];
      end
      if (wb_wr && adr == REG_INTEN) begin
        endie_q <= wdat[STAT_END];
        errie_q <= wdat[STAT_ERR];
      end
    end
  end

  // Region words accepted any time; reserved bits forced to zero
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      for (int k = 0; k < ICR_REGIONS; k++) begin
        region_q[k] <= '0;
      end
    end else if (wr_cfg) begin
      region_q[adr[3:2]] <= icr_region_t'(wdat & 32'h07ff_ff77);
    end
  end

  // ***********************************************************
  // Invalidation and flags
  // ***********************************************************
  // Disabling also wipes the valid bits
  assign invalidate_request_start = wr_ctl &
                       (wdat[CTL_INVALIDATE_REQUEST] | (en_q & ~wdat[CTL_EN]));
  assign inv_done = busy_q & (inv_idx_q == ICR_LAST_IDX) & ~invalidate_request_start;

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_q <= STAT_BUSY_RST;
      inv_idx_q <= 10'h0;
    end else if (invalidate_request_start) begin
      busy_q <= 1'b1;
      inv_idx_q <= 10'h0;
    end else if (busy_q) begin
      inv_idx_q <= inv_idx_q + 10'h1;
      if (inv_done) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      end_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (inv_done) begin
        end_q <= 1'b1;
      end else if (invalidate_request_start || (wr_fc && wdat[STAT_END])) begin
        end_q <= 1'b0;
      end
      if (err_evt) begin
        err_q <= 1'b1;
      end else if (wr_fc && wdat[STAT_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end
  assign IRQ_O = (err_q & errie_q) | (end_q & endie_q);

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      hit_cnt_q <= 32'h0;
      miss_cnt_q <= 16'h0;
    end else begin
      if (wr_ctl && wdat[CTL_HMRST]) begin
        hit_cnt_q <= 32'h0;
      end else if (hmen_q && hit_evt) begin
        hit_cnt_q <= hit_cnt_q + 32'h1;
      end
      if (wr_ctl && wdat[CTL_MMRST]) begin
        miss_cnt_q <= 16'h0;
      end else if (mmen_q && miss_evt) begin
        miss_cnt_q <= miss_cnt_q + 16'h1;
      end
    end
  end

  // ***********************************************************
  // Execution port and lookup
  // ***********************************************************
  icr_state_t state_q;
  logic dp_valid_q, dp_write_q, dp_look_q, capture, exe_ready;
  logic [31:0] dp_addr_q;
  logic [2:0] dp_size_q;
  logic [127:0] data_mem [ICR_WAYS][ICR_LINES];
  logic [17:0] tag_mem [ICR_WAYS][ICR_LINES];
  logic valid_mem [ICR_WAYS][ICR_LINES];
  logic lru_mem [ICR_LINES];
  logic [127:0] rd_data_q [ICR_WAYS];
  logic [17:0] rd_tag_q [ICR_WAYS];
  logic [1:0] rd_vld_q, hit_w;
  logic rd_lru_q, cach, hit, cwr, hit_now, go, victim;
  logic [9:0] rd_idx;
  logic [127:0] hit_line;

  assign capture = EXE_REQ_I.hready & EXE_REQ_I.htrans[1];
  // Index from bits 13:4, tag from 31:14, word from 3:2
  assign rd_idx = capture ? EXE_REQ_I.haddr[13:4]
                          : dp_addr_q[13:4];

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_look_q <= 1'b0;
      dp_addr_q <= 32'h0;
      dp_size_q <= 3'h0;
    end else if (capture) begin
      dp_valid_q <= 1'b1;
      dp_write_q <= EXE_REQ_I.hwrite;
      dp_look_q <= EXE_REQ_I.lookup;
      dp_addr_q <= EXE_REQ_I.haddr;
      dp_size_q <= EXE_REQ_I.hsize;
    end else if (exe_ready) begin
      dp_valid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    for (int w = 0; w < ICR_WAYS; w++) begin
      rd_data_q[w] <= data_mem[w][rd_idx];
      rd_tag_q[w] <= tag_mem[w][rd_idx];
      rd_vld_q[w] <= valid_mem[w][rd_idx];
    end
    rd_lru_q <= lru_mem[rd_idx];
  end

  // Busy makes every access uncacheable
  assign cach = dp_look_q & en_q & ~busy_q;
  always_comb begin
    for (int w = 0; w < ICR_WAYS; w++) begin
      hit_w[w] = rd_vld_q[w] & (rd_tag_q[w] == dp_addr_q[31:14]);
    end
  end
  assign hit = |hit_w;
  assign cwr = dp_write_q & cach;
  assign hit_now = ~dp_write_q & cach & hit;
  assign go = (state_q == ST_IDLE) & dp_valid_q & ~cwr & ~hit_now;
  assign hit_evt = (state_q == ST_IDLE) & dp_valid_q & hit_now;
  assign miss_evt = go;
  assign err_evt = (state_q == ST_IDLE) & dp_valid_q & cwr;
  // Invalid way first, else the pseudo-LRU pointer
  assign victim = ~rd_vld_q[0] ? 1'b0 :
                  (~rd_vld_q[1] ? 1'b1 : rd_lru_q);
  assign hit_line = hit_w[1] ? rd_data_q[1] : rd_data_q[0];

  // ***********************************************************
  // Remap decode
  // ***********************************************************
  logic rg_hit, rg_master_port_select, rg_obt;
  logic [31:0] rg_addr;
  logic [2:0] sz;
  logic [7:0] m8;
  logic [10:0] m11;

  always_comb begin
    rg_hit = 1'b0;
    rg_master_port_select = 1'b0;
    rg_obt = 1'b0;
    rg_addr = dp_addr_q;
    sz = 3'h0;
    m8 = 8'h0;
    m11 = 11'h0;
    for (int k = ICR_REGIONS - 1; k >= 0; k--) begin
      // Exponent is 21 + size; sizes above 128 MB clamp
      sz = (region_q[k].size > ICR_SIZE_MAX) ? ICR_SIZE_MAX
                                              : region_q[k].size;
      m8 = 8'hff << sz;
      m11 = 11'h7ff << sz;
      // Enable alone decides, whatever the cache state
      if (region_q[k].en && dp_addr_q[31:29] == 3'h0 &&
          ((dp_addr_q[28:21] ^ region_q[k].base) & m8) == 8'h0) begin
        rg_hit = 1'b1;
        rg_master_port_select = region_q[k].master_port_select;
        rg_obt = region_q[k].region_burst_type;
        rg_addr = {(region_q[k].remap & m11) | (dp_addr_q[31:21] & ~m11),
                   dp_addr_q[20:0]};
      end
    end
  end

  // ***********************************************************
  // Master engine
  // ***********************************************************
  logic sel_q, wr_q, d_pend_q, crit_rdy_q, vict_q, m_hready, act, beat_in;
  logic [31:0] base_q, rdata_q, m_rdata, ln_addr_q;
  logic [2:0] burst_q, size_q, nbeat_q, a_cnt_q, d_cnt_q;
  logic [1:0] crit_q, a_word, d_word;
  logic [127:0] line_q, line_full;
  logic incr;
  icr_mst_req_t m_req;

  assign m_hready = sel_q ? M1_HREADY_I : M0_HREADY_I;
  assign m_rdata = sel_q ? M1_HRDATA_I : M0_HRDATA_I;
  assign act = ((state_q == ST_SINGLE) | (state_q == ST_REFILL)) &
               (a_cnt_q < nbeat_q);
  assign beat_in = d_pend_q & m_hready;
  assign a_word = base_q[3:2] + a_cnt_q[1:0];
  assign d_word = base_q[3:2] + d_cnt_q[1:0];
  assign incr = rg_hit ? rg_obt : bstt_q;

  always_comb begin
    line_full = line_q;
    line_full[d_word*32 +: 32] = m_rdata;
  end

  always_comb begin
    m_req.htrans = act ? ((a_cnt_q == 3'h0) ? HTRANS_NONSEQ : HTRANS_SEQ)
                       : HTRANS_IDLE;
    m_req.haddr = {base_q[31:4], a_word, base_q[1:0]};
    m_req.hburst = burst_q;
    m_req.hsize = size_q;
    m_req.hwrite = wr_q;
    m_req.hwdata = EXE_HWDATA_I;
  end

  always_comb begin
    M0_REQ_O = m_req;
    M1_REQ_O = m_req;
    if (sel_q) begin
      M0_REQ_O.htrans = HTRANS_IDLE;
    end else begin
      M1_REQ_O.htrans = HTRANS_IDLE;
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      base_q <= 32'h0;
      burst_q <= HBURST_SINGLE;
      size_q <= HSIZE_WORD;
      nbeat_q <= 3'h0;
      crit_q <= 2'h0;
      vict_q <= 1'b0;
      ln_addr_q <= 32'h0;
    end else if (go) begin
      sel_q <= rg_hit & rg_master_port_select;
      vict_q <= victim;
      ln_addr_q <= dp_addr_q;
      crit_q <= dp_addr_q[3:2];
      if (cach) begin
        wr_q <= 1'b0;
        size_q <= HSIZE_WORD;
        nbeat_q <= ICR_LINE_BEATS;
        burst_q <= incr ? HBURST_INCR4 : HBURST_WRAP4;
        // Wrap starts on the wanted word, INCR4 on the line start
        base_q <= incr ? {rg_addr[31:4], 4'h0}
                       : {rg_addr[31:2], 2'b00};
      end else begin
        wr_q <= dp_write_q;
        size_q <= dp_size_q;
        nbeat_q <= ICR_SINGLE_BEATS;
        burst_q <= HBURST_SINGLE;
        base_q <= rg_addr;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      a_cnt_q <= 3'h0;
      d_cnt_q <= 3'h0;
      d_pend_q <= 1'b0;
      line_q <= 128'h0;
      rdata_q <= 32'h0;
      crit_rdy_q <= 1'b0;
    end else begin
      crit_rdy_q <= 1'b0;
      if (go) begin
        a_cnt_q <= 3'h0;
        d_cnt_q <= 3'h0;
        d_pend_q <= 1'b0;
      end else if (m_hready) begin
        d_pend_q <= act;
        if (act) begin
          a_cnt_q <= a_cnt_q + 3'h1;
        end
        if (d_pend_q) begin
          d_cnt_q <= d_cnt_q + 3'h1;
          line_q <= line_full;
          if (state_q == ST_SINGLE || d_word == crit_q) begin
            rdata_q <= m_rdata;
            crit_rdy_q <= (state_q == ST_REFILL);
          end
        end
      end
    end
  end

  // ***********************************************************
  // Sequencer and array updates
  // ***********************************************************
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= cach ? ST_REFILL : ST_SINGLE;
          end
        end
        ST_SINGLE: begin
          if (beat_in) begin
            state_q <= ST_DONE;
          end
        end
        ST_REFILL: begin
          if (beat_in && d_cnt_q == ICR_LINE_BEATS - 3'h1) begin
            state_q <= ST_RECHECK;
          end
        end
        // Lets the array read see the line just written
        ST_RECHECK: state_q <= ST_IDLE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    case (state_q)
      ST_IDLE: exe_ready = ~dp_valid_q | cwr | hit_now;
      ST_DONE: exe_ready = 1'b1;
      default: exe_ready = crit_rdy_q;
    endcase
  end
  assign EXE_HREADYOUT_O = exe_ready;
  assign EXE_HRDATA_O = (state_q == ST_IDLE) ?
                        hit_line[dp_addr_q[3:2]*32 +: 32] : rdata_q;

  logic line_wr;
  assign line_wr = (state_q == ST_REFILL) & beat_in &
                   (d_cnt_q == ICR_LINE_BEATS - 3'h1);

  always_ff @(posedge CLK_I) begin
    if (line_wr) begin
      data_mem[vict_q][ln_addr_q[13:4]] <= line_full;
      tag_mem[vict_q][ln_addr_q[13:4]] <= ln_addr_q[31:14];
    end
  end

  // Arrays carry no reset; the sweep after reset clears only the valid bits
  always_ff @(posedge CLK_I) begin
    if (busy_q) begin
      for (int w = 0; w < ICR_WAYS; w++) begin
        valid_mem[w][inv_idx_q] <= 1'b0;
      end
    end else if (line_wr) begin
      valid_mem[vict_q][ln_addr_q[13:4]] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (line_wr) begin
      lru_mem[ln_addr_q[13:4]] <= ~vict_q;
    end else if (hit_evt) begin
      lru_mem[dp_addr_q[13:4]] <= ~hit_w[1];
    end
  end
endmodule

// ### pkg/icr_pkg.sv
// Purpose: Shared constants and carriers of the remapping instruction cache
// Assumes: 32-bit AHB-style fetch bus, classic Wishbone register bus
// Notes: Register offsets are byte addresses, one word each
package icr_pkg;
  localparam int ICR_WAYS = 2;
  localparam int ICR_LINES = 1024;
  localparam int ICR_IDX_W = 10;
  localparam int ICR_TAG_W = 18;
  localparam int ICR_REGIONS = 4;
  localparam logic [9:0] ICR_LAST_IDX = 10'h3ff;
  localparam logic [2:0] ICR_LINE_BEATS = 3'h4;
  localparam logic [2:0] ICR_SINGLE_BEATS = 3'h1;
  localparam logic [2:0] ICR_SIZE_MAX = 3'h6;

  // Register byte offsets
  localparam logic [7:0] REG_CTL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_INTEN = 8'h08;
  localparam logic [7:0] REG_FC = 8'h0c;
  localparam logic [7:0] REG_HMC = 8'h10;
  localparam logic [7:0] REG_MMC = 8'h14;
  localparam logic [7:0] REG_CFG0 = 8'h20;

  // Control fields
  localparam int CTL_EN = 0;
  localparam int CTL_INVALIDATE_REQUEST = 1;
  localparam int CTL_AMSEL = 2;
  localparam int CTL_BSTT = 3;
  localparam int CTL_HMEN = 16;
  localparam int CTL_MMEN = 17;
  localparam int CTL_HMRST = 18;
  localparam int CTL_MMRST = 19;
  localparam logic CTL_AMSEL_RST = 1'b1;
  // Status, enable and clear fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_END = 1;
  localparam int STAT_ERR = 2;
  localparam logic STAT_BUSY_RST = 1'b1;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_WRAP4 = 3'h2;
  localparam logic [2:0] HBURST_INCR4 = 3'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum {ST_IDLE, ST_SINGLE, ST_REFILL, ST_RECHECK, ST_DONE}
    icr_state_t;

  // Remap region word: en 0, master_port_select 1, obt 2, size 6:4, base 15:8, remap 26:16
  typedef struct packed {
    logic [4:0] rsv3;
    logic [10:0] remap;
    logic [7:0] base;
    logic rsv2;
    logic [2:0] size;
    logic rsv1;
    logic region_burst_type;
    logic master_port_select;
    logic en;
  } icr_region_t;

  typedef struct packed {
    logic hready;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic lookup;
  } icr_exe_req_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [2:0] hburst;
    logic [2:0] hsize;
    logic hwrite;
    logic [31:0] hwdata;
  } icr_mst_req_t;
endpackage

// ### testbench/icr_chk.sv
// Purpose: Port-level checks of the remapping instruction cache
// Assumes: Core HREADY is looped back from EXE_HREADYOUT_O
// Notes: Enable and invalidation state are shadowed from register writes
module icr_chk
  import icr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  input icr_exe_req_t EXE_REQ_I,
  input wire logic EXE_HREADYOUT_O,
  input icr_mst_req_t M0_REQ_O,
  input wire logic M0_HREADY_I,
  input icr_mst_req_t M1_REQ_O,
  input wire logic M1_HREADY_I
);
  logic en_q;
  logic tk;
  logic ctl_wr;
  logic act_rdy;
  logic [10:0] cnt_q;
  logic [31:0] cap_q;
  icr_mst_req_t act;
  assign tk = EXE_REQ_I.hready && EXE_REQ_I.htrans[1];
  assign act = M1_REQ_O.htrans[1] ? M1_REQ_O : M0_REQ_O;
  assign act_rdy = M1_REQ_O.htrans[1] ? M1_HREADY_I : M0_HREADY_I;
  assign ctl_wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O &&
                  WB_ADR_I[7:2] == 6'h0;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      en_q <= 1'b0;
    end else if (ctl_wr) begin
      en_q <= WB_DAT_I[0];
    end
  end
  // Restarts on every sweep: reset, invalidate request, enable falling
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      cnt_q <= 11'h0;
    end else if (ctl_wr && (WB_DAT_I[1] || (en_q && !WB_DAT_I[0]))) begin
      cnt_q <= 11'h0;
    end else if (cnt_q != 11'h7ff) begin
      cnt_q <= cnt_q + 11'h1;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (tk) begin
      cap_q <= EXE_REQ_I.haddr;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_one_master: assert property (
    !(M0_REQ_O.htrans[1] && M1_REQ_O.htrans[1])) else $error("two masters");
  a_low_bits: assert property (
    act.htrans == HTRANS_NONSEQ |-> act.haddr[20:4] == cap_q[20:4])
    else $error("master address low bits changed");
  a_incr_aligned: assert property (
    act.htrans == HTRANS_NONSEQ && act.hburst == HBURST_INCR4
    |-> act.haddr[3:0] == 4'h0) else $error("INCR4 not line aligned");
  a_burst_seq: assert property (
    act.htrans == HTRANS_NONSEQ && act.hburst != HBURST_SINGLE && act_rdy
    |=> act.htrans == HTRANS_SEQ) else $error("refill burst broken");
  a_busy_uncached: assert property (
    tk && cnt_q < 11'h3e8 |-> ##2 act.htrans == HTRANS_NONSEQ)
    else $error("access cached while busy");
  a_bypass_single: assert property (
    tk && (!EXE_REQ_I.lookup || !en_q)
    |-> ##2 act.htrans == HTRANS_NONSEQ && act.hburst == HBURST_SINGLE)
    else $error("bypass access not single");
  a_attr_kept: assert property (
    tk && !EXE_REQ_I.lookup
    |-> ##2 act.hsize == $past(EXE_REQ_I.hsize, 2) &&
    act.hwrite == $past(EXE_REQ_I.hwrite, 2))
    else $error("attributes changed");
  a_write_dropped: assert property (
    tk && EXE_REQ_I.hwrite && EXE_REQ_I.lookup && en_q && cnt_q > 11'h410
    |=> EXE_HREADYOUT_O && !act.htrans[1]) else $error("write not dropped");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
endmodule
bind icr_top icr_chk icr_chk_inst (.CLK_I, .RESETN_I, .WB_CYC_I, .WB_STB_I,
  .WB_WE_I, .WB_ADR_I, .WB_DAT_I, .WB_ACK_O, .EXE_REQ_I, .EXE_HREADYOUT_O,
  .M0_REQ_O, .M0_HREADY_I, .M1_REQ_O, .M1_HREADY_I);

// ### testbench/icr_mem.sv
// Purpose: AHB memory behind one master port
// Assumes: Word reads, data is the word address xor a mask
// Notes: Writes are accepted and discarded
module icr_mem
  import icr_pkg::*;
#(
  parameter int WAIT = 0,
  parameter logic [31:0] MASK = 32'h0
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input icr_mst_req_t req_i,
  output logic hready_o,
  output logic [31:0] hrdata_o
);
  logic dp_q;
  logic [31:0] adr_q;
  logic [31:0] last_q;
  int w_q;
  assign hready_o = !dp_q || w_q == 0;
  // Idle bus shows the inverse of the last word, never a stale copy
  assign hrdata_o = (dp_q && w_q == 0) ? ({adr_q[31:2], 2'h0} ^ MASK) : ~last_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_q <= 1'b0;
      adr_q <= 32'h0;
      last_q <= 32'h0;
      w_q <= 0;
    end else if (hready_o) begin
      if (dp_q) begin
        last_q <= hrdata_o;
      end
      dp_q <= req_i.htrans[1];
      adr_q <= req_i.haddr;
      w_q <= WAIT;
    end else begin
      w_q <= w_q - 1;
    end
  end
endmodule

// ### testbench/icr_top_tb.sv
// Purpose: Self-checking bench of the remapping instruction cache
// Assumes: Fast memory answers at once, slow memory after two waits
// Notes: Region 0 maps 2 MB at 0x1000_0000 onto 0x9000_0000
module icr_top_tb
  import icr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] M0_MASK = 32'h0f0f_0000;
  localparam logic [31:0] M1_MASK = 32'hf00f_00f0;
  localparam logic [31:0] REGION0 = 32'h0480_8007;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic lookup = 1'b0;
  logic [31:0] rdat, hrdata, m0_d, m1_d;
  logic ack, hrdy, irq, m0_rdy, m1_rdy;
  icr_exe_req_t exe;
  icr_mst_req_t m0, m1;
  int num_errors = 0;
  int checks = 0;
  int hit_n, miss_n;
  assign exe = {hrdy, htrans, haddr, hwrite, HSIZE_WORD, lookup};
  always #25 clk = ~clk;
  icr_top icr_top_inst (.CLK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .EXE_REQ_I(exe),
    .EXE_HWDATA_I(32'h0), .EXE_HREADYOUT_O(hrdy), .EXE_HRDATA_O(hrdata),
    .M0_REQ_O(m0), .M0_HREADY_I(m0_rdy), .M0_HRDATA_I(m0_d), .M1_REQ_O(m1),
    .M1_HREADY_I(m1_rdy), .M1_HRDATA_I(m1_d), .IRQ_O(irq));
  icr_mem #(.WAIT(0), .MASK(M0_MASK)) icr_mem_inst (.clk_i(clk),
    .rst_n_i(rst_n), .req_i(m0), .hready_o(m0_rdy), .hrdata_o(m0_d));
  icr_mem #(.WAIT(2), .MASK(M1_MASK)) icr_mem_slow_inst (.clk_i(clk),
    .rst_n_i(rst_n), .req_i(m1), .hready_o(m1_rdy), .hrdata_o(m1_d));
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    check(n < 20, "no bus ack");
  endtask
  task automatic xfer(input logic [31:0] a, input logic lk, input logic w,
                      output logic [31:0] q, output int waits);
    int n;
    n = 0;
    waits = 0;
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    lookup <= lk;
    hwrite <= w;
    // Address phase holds while a refill still stalls the port
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 100);
    htrans <= HTRANS_IDLE;
    check(n < 100, "address phase never accepted");
    @(negedge clk);
    while (hrdy !== 1'b1 && waits < 100) begin
      @(negedge clk);
      waits++;
    end
    q = hrdata;
    @(posedge clk);
  endtask
  function automatic logic [31:0] exp_word(input logic [31:0] a);
    if (a[31:21] == 11'h080) begin
      return {11'h480, a[20:2], 2'h0} ^ M1_MASK;
    end
    return {a[31:2], 2'h0} ^ M0_MASK;
  endfunction
  task automatic fetch(input logic [31:0] a, input logic lk, input logic hit);
    logic [31:0] q;
    int w;
    xfer(a, lk, 1'b0, q, w);
    check(q === exp_word(a), "fetch data");
    check((w == 0) === hit, "wait states");
    if (hit) begin
      hit_n++;
    end else begin
      miss_n++;
    end
  endtask
  task automatic wait_idle(output logic [31:0] q);
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0, q);
      n++;
    end while (q[STAT_BUSY] !== 1'b0 && n < 400);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_boot();
    logic [31:0] q;
    wb(1'b0, REG_STAT, 32'h0, q);
    check(q === 32'h1, "busy after reset");
    wb(1'b0, REG_CTL, 32'h0, q);
    check(q === 32'h4, "control reset value");
    wb(1'b0, 8'h40, 32'h0, q);
    check(q === 32'h0, "unmapped read");
    wb(1'b1, REG_INTEN, 32'h6, q);
    wb(1'b1, REG_CFG0, REGION0, q);
    wb(1'b0, REG_CFG0, 32'h0, q);
    check(q === REGION0, "region readback");
    fetch(32'h1000_1234, 1'b1, 1'b0);
    fetch(32'h0000_0100, 1'b1, 1'b0);
    wb(1'b1, REG_CTL, 32'h1, q);
    fetch(32'h0000_0200, 1'b1, 1'b0);
    fetch(32'h0000_0200, 1'b1, 1'b0);
    wait_idle(q);
    check(q === 32'h2, "end flag after sweep");
    check(irq === 1'b1, "end interrupt");
    wb(1'b1, REG_FC, 32'h2, q);
    check(irq === 1'b0, "end interrupt cleared");
  endtask
  task automatic t_cache();
    logic [31:0] q;
    hit_n = 0;
    miss_n = 0;
    wb(1'b1, REG_CTL, 32'h000f_0001, q);
    fetch(32'h0000_0340, 1'b1, 1'b0);
    fetch(32'h0000_0340, 1'b1, 1'b1);
    fetch(32'h0000_034c, 1'b1, 1'b1);
    fetch(32'h0000_4340, 1'b1, 1'b0);
    fetch(32'h0000_0340, 1'b1, 1'b1);
    fetch(32'h0000_8340, 1'b1, 1'b0);
    fetch(32'h0000_0340, 1'b1, 1'b1);
    fetch(32'h0000_4340, 1'b1, 1'b0);
    fetch(32'h0000_0340, 1'b0, 1'b0);
    fetch(32'h1000_2008, 1'b1, 1'b0);
    fetch(32'h1000_2000, 1'b1, 1'b1);
    wb(1'b0, REG_HMC, 32'h0, q);
    check(q === 32'(hit_n), "hit count");
    wb(1'b0, REG_MMC, 32'h0, q);
    check(q === 32'(miss_n), "miss count");
  endtask
  task automatic t_err();
    logic [31:0] q;
    int w;
    xfer(32'h0000_0400, 1'b1, 1'b1, q, w);
    check(w == 0, "cacheable write waited");
    wb(1'b0, REG_STAT, 32'h0, q);
    check(q === 32'h4, "error flag");
    check(irq === 1'b1, "error interrupt");
    wb(1'b1, REG_FC, 32'h4, q);
    check(irq === 1'b0, "error cleared");
    wb(1'b1, REG_CTL, 32'h0, q);
    wait_idle(q);
    wb(1'b1, REG_CTL, 32'h1, q);
    fetch(32'h0000_034c, 1'b1, 1'b0);
  endtask
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_cache();
    t_err();
    conclude();
  end
  // Sweeps take 1024 cycles each, the rest a few hundred
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
endmodule
